//--- hdl/sac_pkg.sv
// Shared constants, pin bundle and state type of the converter control
`default_nettype none
package sac_pkg;
  // Result width and its documented default
  localparam int RES_W_DEF      = 12;
  // Clock rate in MHz
  localparam int CLK_MHZ        = 40;
  // Nap wake-up time in ns and its cycle count, rounded up
  localparam int NAP_WAKE_NS    = 200;
  localparam int NAP_WAKE_CYC   = (NAP_WAKE_NS * CLK_MHZ + 999) / 1000;
  // Default sleep wake-up cycles
  localparam int SLEEP_WAKE_DEF = 400;
  // Default cycles spent on each bit decision
  localparam int BIT_CYC_DEF    = 2;
  // Reset value of the result latches
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Control pins as they arrive from the bus
  typedef struct packed {
    logic cs_n;      // chip_select_n
    logic convert_start_n_n;  // convert_start_n
    logic rd_n;      // read_n
    logic power_down_n_n;    // power_down_n
    logic nap_sel;   // shutdown_depth_select
  } sac_pins_s;

  // Idle level of the pins after reset
  localparam sac_pins_s PINS_RST = 5'h1E;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_WAKE, ST_IDLE, ST_CLEAR, ST_TRIAL, ST_LOAD, ST_DONE
  } sac_state_e;
endpackage
`default_nettype wire

//--- hdl/sac_ctrl.sv
// Conversion sequencer, result latches and shutdown control of the converter
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int RES_W          = sac_pkg::RES_W_DEF,
  parameter int BIT_CYC        = sac_pkg::BIT_CYC_DEF,
  parameter int SLEEP_WAKE_CYC = sac_pkg::SLEEP_WAKE_DEF
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire sac_pkg::sac_pins_s pins_async,
  input  wire logic              comp_high,
  output logic                   busy,
  output logic [RES_W-1:0]       result_bits_o,
  output logic                   result_bits_oe,
  output logic [RES_W-1:0]       dac_word,
  output logic                   sample_en,
  output logic                   nap_active,
  output logic                   sleep_active
);
  import sac_pkg::*;

  // Refuse shapes the counters cannot serve
  if (RES_W < 2 || RES_W > 16)
    $error("RES_W must lie in 2..16");
  if (BIT_CYC < 1 || BIT_CYC > 65535)
    $error("BIT_CYC must lie in 1..65535");
  if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC > 65535)
    $error("SLEEP_WAKE_CYC must lie in 1..65535");

  localparam logic [15:0] BIT_LAST   = 16'(BIT_CYC - 1);
  localparam logic [15:0] NAP_LAST   = 16'(NAP_WAKE_CYC - 1);
  localparam logic [15:0] SLEEP_LAST = 16'(SLEEP_WAKE_CYC - 1);
  localparam logic [3:0]  MSB_IDX    = 4'(RES_W - 1);

  // Pin synchroniser state
  sac_pins_s  s1_q, s1_d;
  sac_pins_s  s2_q, s2_d;
  logic       convert_start_n_prev_q, convert_start_n_prev_d;

  // Sequencer state
  sac_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  bit_q, bit_d;
  logic [RES_W-1:0] sar_q, sar_d;
  logic [RES_W-1:0] res_q, res_d;
  logic        busy_q, busy_d;
  logic        napping_q, napping_d;
  logic        nap_q, nap_d;
  logic        sleep_q, sleep_d;

  logic        start_fall;
  logic        pwr_ok;

  // Two-stage capture of every pin, plus edge history
  always_comb
  begin
    s1_d          = pins_async;
    s2_d          = s1_q;
    convert_start_n_prev_d = s2_q.convert_start_n_n;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q          <= PINS_RST;
      s2_q          <= PINS_RST;
      convert_start_n_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      s1_q          <= s1_d;
      s2_q          <= s2_d;
      convert_start_n_prev_q <= convert_start_n_prev_d;
    end
  end

  // Falling start edge counts only while selected
  assign start_fall = !s2_q.cs_n && convert_start_n_prev_q
                      && !s2_q.convert_start_n_n;
  assign pwr_ok     = s2_q.power_down_n_n;

  // Sequencer next-state and datapath
  always_comb
  begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    bit_d     = bit_q;
    sar_d     = sar_q;
    res_d     = res_q;
    busy_d    = busy_q;
    napping_d = napping_q;
    nap_d     = !pwr_ok && s2_q.nap_sel;
    sleep_d   = !pwr_ok && !s2_q.nap_sel;
    if (!pwr_ok)
    begin
      // Shutdown abandons any conversion and keeps the last result
      st_d      = ST_OFF;
      busy_d    = 1'b1;
      sar_d     = '0;
      napping_d = s2_q.nap_sel;
    end
    else
    begin
      case (st_q)
        ST_OFF:
        begin
          st_d  = ST_WAKE;
          cnt_d = napping_q ? NAP_LAST : SLEEP_LAST;
        end
        ST_WAKE:
        begin
          if (cnt_q == 16'h0000)
            st_d = ST_IDLE;
          else
            cnt_d = cnt_q - 16'h0001;
        end
        ST_IDLE:
        begin
          // Only idle accepts a start, so a running one is never restarted
          if (start_fall)
          begin
            st_d   = ST_CLEAR;
            busy_d = 1'b0;
          end
        end
        ST_CLEAR:
        begin
          // Clear the register, then place the MSB trial
          sar_d          = '0;
          sar_d[MSB_IDX] = 1'b1;
          bit_d          = MSB_IDX;
          cnt_d          = BIT_LAST;
          st_d           = ST_TRIAL;
        end
        ST_TRIAL:
        begin
          // Internal clock paces each decision
          if (cnt_q != 16'h0000)
            cnt_d = cnt_q - 16'h0001;
          else
          begin
            if (!comp_high)
              sar_d[bit_q] = 1'b0;
            if (bit_q == 4'h0)
              st_d = ST_LOAD;
            else
            begin
              bit_d            = bit_q - 4'h1;
              sar_d[bit_q-1'b1] = 1'b1;
              cnt_d            = BIT_LAST;
            end
          end
        end
        ST_LOAD:
        begin
          // Offset word to two's complement by flipping the sign bit
          res_d = {!sar_q[RES_W-1], sar_q[RES_W-2:0]};
          st_d  = ST_DONE;
        end
        ST_DONE:
        begin
          busy_d = 1'b1;
          st_d   = ST_IDLE;
        end
        default:
        begin
          st_d   = ST_IDLE;
          busy_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q      <= ST_IDLE;
      cnt_q     <= 16'h0000;
      bit_q     <= 4'h0;
      sar_q     <= '0;
      res_q     <= RESULT_RST[RES_W-1:0];
      busy_q    <= 1'b1;
      napping_q <= 1'b0;
      nap_q     <= 1'b0;
      sleep_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      sar_q     <= sar_d;
      res_q     <= res_d;
      busy_q    <= busy_d;
      napping_q <= napping_d;
      nap_q     <= nap_d;
      sleep_q   <= sleep_d;
    end
  end

  // Output pins
  assign busy           = busy_q;
  assign result_bits_o  = res_q;
  assign result_bits_oe = !s2_q.cs_n && !s2_q.rd_n;
  assign dac_word       = sar_q;
  assign sample_en      = (st_q == ST_IDLE);
  assign nap_active     = nap_q;
  assign sleep_active   = sleep_q;

  // Checks run only on enabled edges
  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (!arst_n);

  sequence s_trial_end;
    pwr_ok && st_q == ST_TRIAL && cnt_q == 16'h0000 && bit_q == 4'h0;
  endsequence

  sequence s_finish;
    pwr_ok && st_q == ST_LOAD ##1 pwr_ok && st_q == ST_DONE;
  endsequence

  property p_drive_sel;
    result_bits_oe
      |-> !$past(pins_async.cs_n, 2) && !$past(pins_async.rd_n, 2);
  endproperty
  a_drive_sel: assert property (p_drive_sel)
    else $error("result driven without read and select");

  property p_start;
    pwr_ok && st_q == ST_IDLE && start_fall |=> !busy && st_q == ST_CLEAR;
  endproperty
  a_start: assert property (p_start)
    else $error("start edge did not begin a conversion");

  property p_unselected;
    pwr_ok && st_q == ST_IDLE && s2_q.cs_n |=> st_q == ST_IDLE && busy;
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("conversion started while deselected");

  property p_no_restart;
    st_q == ST_TRIAL
      |=> st_q == ST_TRIAL || st_q == ST_LOAD || st_q == ST_OFF;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("running conversion restarted");

  property p_clear;
    pwr_ok && st_q == ST_CLEAR
      |=> sar_q == (RES_W'(1) << MSB_IDX) && bit_q == MSB_IDX;
  endproperty
  a_clear: assert property (p_clear)
    else $error("register not cleared at conversion start");

  property p_msb_first;
    pwr_ok && st_q == ST_TRIAL && cnt_q == 16'h0000 && bit_q != 4'h0
      |=> bit_q == $past(bit_q) - 4'h1 && sar_q[bit_q];
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("bit order broken");

  property p_load;
    pwr_ok && st_q == ST_LOAD
      |=> result_bits_o == {!$past(sar_q[RES_W-1]), $past(sar_q[RES_W-2:0])};
  endproperty
  a_load: assert property (p_load)
    else $error("result latch mismatch");

  property p_busy_rise;
    s_trial_end ##1 s_finish |=> busy && $stable(result_bits_o);
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise after the last bit");

  property p_busy_low;
    st_q == ST_CLEAR || st_q == ST_TRIAL || st_q == ST_LOAD |-> !busy;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy high during conversion");

  property p_shutdown;
    !pwr_ok |=> st_q == ST_OFF && busy
      && nap_active == $past(s2_q.nap_sel)
      && sleep_active == !$past(s2_q.nap_sel);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown mode wrong");

  property p_nap_wake;
    st_q == ST_WAKE && $past(st_q) == ST_OFF && napping_q
      ##0 pwr_ok [*8] |=> st_q == ST_IDLE;
  endproperty
  a_nap_wake: assert property (p_nap_wake)
    else $error("nap wake-up interval wrong");

endmodule
`default_nettype wire

//--- tb/sac_analog_model.sv
// Comparator stand-in that answers trial words against a held input code
`default_nettype none
module sac_analog_model (
  input  wire logic [11:0] dac_word,
  input  wire logic [11:0] target,
  output logic             comp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  // Keep the trial bit while the held input is at or above the trial word
  assign comp_high = (target >= dac_word);
endmodule
`default_nettype wire

//--- tb/sac_ctrl_bench.sv
// Self-checking bench for the converter control
`default_nettype none
module sac_ctrl_bench;
  import sac_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;
  logic        smp;
  logic        arst_n;
  logic        clk_en;
  sac_pins_s   pins;
  logic        comp_high;
  logic        busy;
  logic        oe;
  logic        nap_on;
  logic        sleep_on;
  logic [11:0] res;
  logic [11:0] dac;
  logic [11:0] target;
  logic [11:0] last_res;
  logic [11:0] lowc;
  logic [31:0] rnd;
  logic [11:0] q[$];
  int          seed;
  int          fail_count;
  int          checked;

  sac_ctrl #(.RES_W(12), .BIT_CYC(2), .SLEEP_WAKE_CYC(10)) dut_u (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pins_async(pins),
    .comp_high(comp_high), .busy(busy), .result_bits_o(res),
    .result_bits_oe(oe), .dac_word(dac), .sample_en(smp),
    .nap_active(nap_on), .sleep_active(sleep_on)
  );
  sac_analog_model model_u (
    .dac_word(dac), .target(target), .comp_high(comp_high)
  );

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Compare one value and count it
  task automatic chk(input string nm, input logic [11:0] s, e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One conversion with a second start edge while it runs
  task automatic convert(input logic [11:0] t);
    int n;
    target = t;
    last_res = {~t[11], t[10:0]};
    q.push_back(last_res);
    pins.convert_start_n_n = 1'b0;
    repeat (6) @(negedge clk);
    pins.convert_start_n_n = 1'b1;
    repeat (3) @(negedge clk);
    pins.convert_start_n_n = 1'b0;
    repeat (3) @(negedge clk);
    pins.convert_start_n_n = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    // A busy that never rises counts as a mismatch here
    chk("busy_end", {11'h000, busy}, 12'h001);
    repeat (5) @(negedge clk);
  endtask

  // Read strobe with the given chip select level
  task automatic read_chk(input logic cs);
    pins.cs_n = cs;
    pins.rd_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("oe_on", {11'h000, oe}, {11'h000, ~cs});
    chk("data", res, last_res);
    pins.rd_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("oe_off", {11'h000, oe}, 12'h000);
    pins.cs_n = 1'b0;
  endtask

  // Each busy rise retires the oldest expected result
  always @(negedge clk)
  begin
    if (busy === 1'b0)
      lowc++;
    else if (lowc != 12'h000)
    begin
      chk("busy_low", lowc, 12'h01B);
      chk("pending", 12'(q.size()), 12'h001);
      if (q.size() != 0)
        chk("result", res, q.pop_front());
      lowc = 12'h000;
    end
  end

  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    clk = 1'b0;
    seed = 3;
    pins = PINS_RST;
    target = 12'h000;
    lowc = 12'h000;
    clk_en = 1'b1;
    arst_n = 1'b0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    chk("rst_res", res, 12'h000);
    chk("rst_busy", {11'h000, busy}, 12'h001);
    chk("rst_idle", {11'h000, smp}, 12'h001);
    pins.cs_n = 1'b0;
    repeat (4) @(negedge clk);
    convert(12'h000);
    convert(12'hFFF);
    convert(12'h800);
    repeat (5)
    begin
      rnd = $random(seed);
      convert(rnd[11:0]);
    end
    // Frozen clock enable: a start edge meanwhile is never seen
    clk_en = 1'b0;
    pins.convert_start_n_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("frozen", {11'h000, busy}, 12'h001);
    pins.convert_start_n_n = 1'b1;
    repeat (2) @(negedge clk);
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    read_chk(1'b0);
    read_chk(1'b1);
    // Start edge with chip select high is dropped
    pins.cs_n = 1'b1;
    pins.convert_start_n_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("no_cs", {11'h000, busy}, 12'h001);
    pins.convert_start_n_n = 1'b1;
    pins.cs_n = 1'b0;
    // Sleep, then nap, with starts refused meanwhile
    pins.nap_sel = 1'b0;
    repeat (2) @(negedge clk);
    pins.power_down_n_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("sleep", {10'h000, nap_on, sleep_on}, 12'h001);
    pins.convert_start_n_n = 1'b0;
    pins.nap_sel = 1'b1;
    repeat (6) @(negedge clk);
    chk("off_busy", {11'h000, busy}, 12'h001);
    chk("nap", {10'h000, nap_on, sleep_on}, 12'h002);
    pins.convert_start_n_n = 1'b1;
    pins.power_down_n_n = 1'b1;
    // Two sync edges and one off cycle precede the nap wake-up count
    repeat (4) @(negedge clk);
    pins.convert_start_n_n = 1'b0;
    repeat (NAP_WAKE_CYC - 2) @(negedge clk);
    chk("wake_busy", {11'h000, busy}, 12'h001);
    chk("wake_idle", {11'h000, smp}, 12'h000);
    pins.convert_start_n_n = 1'b1;
    @(negedge clk);
    chk("wake_done", {11'h000, smp}, 12'h001);
    repeat (5) @(negedge clk);
    convert(12'h7FF);
    repeat (4) @(negedge clk);
    chk("queue", 12'(q.size()), 12'h000);
    end_sim();
  end
endmodule
`default_nettype wire
